// ===== hdl/afe_spi_pkg.sv
// package of register offsets, field positions, reset values and buffer sizes
// assumes a 7-bit address space of 8-bit registers reached over a serial host port
`default_nettype none
package afe_spi_pkg;
    // register offsets
    localparam logic [6:0] ADDR_STREAM_CONTROL = 7'h03;
    localparam logic [6:0] ADDR_BURST_READ_START = 7'h09;
    localparam logic [6:0] ADDR_BURST_READ_LENGTH = 7'h0a;
    localparam logic [6:0] ADDR_PIN_DIRECTION = 7'h0e;
    localparam logic [6:0] ADDR_READY_PIN_CONTROL = 7'h11;
    localparam logic [6:0] ADDR_CHECKSUM_CONTROL = 7'h13;
    localparam logic [6:0] ADDR_CHECKSUM_VALUE = 7'h14;
    localparam logic [6:0] ADDR_RESULT_HIGH = 7'h1a;
    localparam logic [6:0] ADDR_RESULT_LOW = 7'h1b;
    // field positions
    localparam int STREAM_TYPE_BIT = 7;
    localparam int READY_ON_PIN_SIX_BIT = 7;
    localparam int READY_NO_CLEAR_BIT = 5;
    localparam int GAIN_BG_CORR_BIT = 3;
    localparam int CHECKSUM_ENABLE_BIT = 4;
    localparam int READY_AFTER_CHECKSUM_BIT = 2;
    localparam int READ_CMD_BIT = 7;
    // writable masks: reserved bits read as the reset value or zero
    localparam logic [7:0] MASK_STREAM_CONTROL = 8'hff;
    localparam logic [7:0] MASK_BURST_READ_START = 8'h7f;
    localparam logic [7:0] MASK_BURST_READ_LENGTH = 8'h07;
    localparam logic [7:0] MASK_READY_PIN_CONTROL = 8'ha8;
    localparam logic [7:0] MASK_CHECKSUM_CONTROL = 8'h14;
    localparam logic [7:0] MASK_PIN_DIRECTION = 8'h7f;
    // reset values
    localparam logic [7:0] RST_STREAM_CONTROL = 8'h00;
    localparam logic [7:0] RST_BURST_READ_START = 8'h1a;
    localparam logic [7:0] RST_BURST_READ_LENGTH = 8'h02;
    localparam logic [7:0] RST_READY_PIN_CONTROL = 8'h03;
    localparam logic [7:0] RST_CHECKSUM_CONTROL = 8'h08;
    localparam logic [7:0] RST_PIN_DIRECTION = 8'h00;
    // checksum polynomial x^8 + x^2 + x + 1
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;
    // result buffer and general pins
    localparam int BUF_DEPTH = 2;
    localparam int BUF_WIDTH = 8;
    localparam int PIN_COUNT = 7;
    localparam int READY_PIN = 6;
endpackage : afe_spi_pkg
`default_nettype wire

// ===== hdl/sensor_afe_spi_control_regs.sv
// serial host port control registers, checksum and data-ready logic
// assumes sclk, csLow and mosi are synchronous to clock and far slower than it
`default_nettype none
module sensor_afe_spi_control_regs
    import afe_spi_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic sclk,
    input wire logic csLow,
    input wire logic mosi,
    output logic sdo,
    output logic sdoOe,
    input wire logic [afe_spi_pkg::BUF_WIDTH-1:0] resultByte,
    input wire logic resultValid,
    output logic resultReady,
    input wire logic [afe_spi_pkg::PIN_COUNT-1:0] pinIn,
    input wire logic [afe_spi_pkg::PIN_COUNT-1:0] pinDrive,
    output logic [afe_spi_pkg::PIN_COUNT-1:0] pinOut,
    output logic [afe_spi_pkg::PIN_COUNT-1:0] pinOe,
    output logic [afe_spi_pkg::PIN_COUNT-1:0] pinSeen,
    output logic readyLow,
    output logic streamControlled,
    output logic [6:0] streamRange,
    output logic [6:0] burstStartAddr,
    output logic [3:0] burstByteCount,
    output logic gainBgCorrection,
    output logic checksumEnable
);
    import afe_spi_pkg::*;

    typedef struct packed {
        logic [7:0] streamCtl;
        logic [7:0] burstStart;
        logic [7:0] burstLen;
        logic [7:0] readyCtl;
        logic [7:0] crcCtl;
        logic [7:0] pinDir;
        logic [7:0] crc;
        logic [BUF_DEPTH-1:0][BUF_WIDTH-1:0] bufMem;
        logic [1:0] bufCount;
        logic readyLow;
        logic waitChecksum;
        logic headSent;
        logic sclkPrev;
        logic [2:0] bitCnt;
        logic inCmd;
        logic isRead;
        logic [7:0] rxShift;
        logic [7:0] txShift;
        logic [6:0] addr;
        logic [6:0] frameAddr;
        logic [6:0] streamCnt;
    } state_s;

    state_s state_ff;
    state_s nxt_state;

    // checksum update over one byte, msb first
    function automatic logic [7:0] crcByte(input logic [7:0] crcIn, input logic [7:0] dat);
        logic [7:0] c;
        c = crcIn ^ dat;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction : crcByte

    logic sclkRise;
    logic sclkFall;
    logic byteDone;
    logic [7:0] rxByte;
    logic [6:0] rdAddr;
    logic [7:0] rdData;
    logic doRead;
    logic doWrite;
    logic bufPop;
    logic bufPush;
    logic commit;
    logic [6:0] nextAddr;

    // edge detection on the sampled serial clock; frame active only with csLow
    assign sclkRise = !csLow && sclk && !state_ff.sclkPrev;
    assign sclkFall = !csLow && !sclk && state_ff.sclkPrev;
    assign byteDone = sclkRise && (state_ff.bitCnt == 3'h7);
    assign rxByte = {state_ff.rxShift[6:0], mosi};
    assign resultReady = (state_ff.bufCount != 2'(BUF_DEPTH)); // stalls producer when full
    assign bufPush = resultValid && resultReady;

    // address stepping: normal streaming counts up, controlled wraps after range+1
    always_comb begin
        nextAddr = 7'(state_ff.addr + 7'h01);
        if (state_ff.streamCtl[STREAM_TYPE_BIT] &&
            (state_ff.streamCnt >= state_ff.streamCtl[6:0])) begin
            nextAddr = state_ff.frameAddr;
        end
    end

    // read address is the command address for the first byte, then the stepped one
    assign rdAddr = state_ff.inCmd ? rxByte[6:0] : nextAddr;
    assign doRead = byteDone && (state_ff.inCmd ? rxByte[READ_CMD_BIT] : state_ff.isRead);
    assign doWrite = byteDone && !state_ff.inCmd && !state_ff.isRead;

    // read mux; reserved bits come out as stored masked values
    always_comb begin
        rdData = 8'h00; // unmapped addresses read as zero
        if (rdAddr == ADDR_STREAM_CONTROL) begin
            rdData = state_ff.streamCtl;
        end else if (rdAddr == ADDR_BURST_READ_START) begin
            rdData = state_ff.burstStart;
        end else if (rdAddr == ADDR_BURST_READ_LENGTH) begin
            rdData = state_ff.burstLen;
        end else if (rdAddr == ADDR_PIN_DIRECTION) begin
            rdData = state_ff.pinDir;
        end else if (rdAddr == ADDR_READY_PIN_CONTROL) begin
            rdData = state_ff.readyCtl;
        end else if (rdAddr == ADDR_CHECKSUM_CONTROL) begin
            rdData = state_ff.crcCtl;
        end else if (rdAddr == ADDR_CHECKSUM_VALUE) begin
            rdData = state_ff.crc;
        end else if (rdAddr == ADDR_RESULT_HIGH || rdAddr == ADDR_RESULT_LOW) begin
            rdData = (state_ff.bufCount != 2'h0) ? state_ff.bufMem[0] : 8'h00;
        end
    end

    // a read byte takes effect when the host samples its first bit; the byte
    // loaded ahead at the end of a frame is never sent and so has no effect
    assign commit = sclkRise && !state_ff.inCmd && state_ff.isRead &&
                    (state_ff.bitCnt == 3'h0);
    assign bufPop = commit && state_ff.headSent;

    // next-state logic for serial engine, registers, buffer and checksum
    always_comb begin
        logic releaseReady;
        logic lastByte;
        logic [1:0] pushSlot;
        releaseReady = 1'b0;
        lastByte = 1'b0;
        pushSlot = 2'h0;
        nxt_state = state_ff;
        nxt_state.sclkPrev = sclk;

        // serial shifting, mode 0: sample on rise, shift out on fall
        if (csLow) begin
            nxt_state.bitCnt = 3'h0;
            nxt_state.inCmd = 1'b1;
        end else begin
            if (sclkRise) begin
                nxt_state.rxShift = rxByte;
                nxt_state.bitCnt = 3'(state_ff.bitCnt + 3'h1);
            end
            // the fall after a byte boundary keeps the freshly loaded msb on sdo
            if (sclkFall && state_ff.bitCnt != 3'h0) begin
                nxt_state.txShift = {state_ff.txShift[6:0], 1'b0};
            end
            if (byteDone) begin
                nxt_state.inCmd = 1'b0;
                if (state_ff.inCmd) begin
                    nxt_state.isRead = rxByte[READ_CMD_BIT];
                    nxt_state.addr = rxByte[6:0];
                    nxt_state.frameAddr = rxByte[6:0];
                    nxt_state.streamCnt = 7'h00;
                end else if (state_ff.isRead) begin
                    nxt_state.addr = nextAddr;
                    nxt_state.streamCnt = (nextAddr == state_ff.frameAddr) ? 7'h00 :
                                          7'(state_ff.streamCnt + 7'h01);
                end
            end
            if (doRead) begin
                nxt_state.txShift = rdData;
                // remember whether the loaded byte is the buffer head, so only
                // a byte that really leaves the buffer can pop it
                nxt_state.headSent = (state_ff.bufCount != 2'h0) &&
                                     (rdAddr == ADDR_RESULT_HIGH || rdAddr == ADDR_RESULT_LOW);
            end
        end

        // register writes, reserved bits held at reset value
        if (doWrite) begin
            if (state_ff.addr == ADDR_STREAM_CONTROL) begin
                nxt_state.streamCtl = rxByte & MASK_STREAM_CONTROL;
            end else if (state_ff.addr == ADDR_BURST_READ_START) begin
                nxt_state.burstStart = rxByte & MASK_BURST_READ_START;
            end else if (state_ff.addr == ADDR_BURST_READ_LENGTH) begin
                nxt_state.burstLen = rxByte & MASK_BURST_READ_LENGTH;
            end else if (state_ff.addr == ADDR_PIN_DIRECTION) begin
                nxt_state.pinDir = rxByte & MASK_PIN_DIRECTION;
            end else if (state_ff.addr == ADDR_READY_PIN_CONTROL) begin
                nxt_state.readyCtl = (rxByte & MASK_READY_PIN_CONTROL) |
                                     (RST_READY_PIN_CONTROL & ~MASK_READY_PIN_CONTROL);
            end else if (state_ff.addr == ADDR_CHECKSUM_CONTROL) begin
                nxt_state.crcCtl = (rxByte & MASK_CHECKSUM_CONTROL) |
                                   (RST_CHECKSUM_CONTROL & ~MASK_CHECKSUM_CONTROL);
            end
        end

        // checksum accumulates every byte the host takes while enabled, except the checksum value
        // itself, over the very byte on the wire; a byte loaded ahead at frame end is not counted
        if (commit && state_ff.crcCtl[CHECKSUM_ENABLE_BIT] &&
            state_ff.addr != ADDR_CHECKSUM_VALUE) begin
            nxt_state.crc = crcByte(state_ff.crc, state_ff.txShift);
        end

        // result buffer: pop the head, shift, then append
        lastByte = bufPop && (state_ff.bufCount == 2'h1 ||
                   (state_ff.bufCount == 2'h2 && state_ff.addr == ADDR_RESULT_LOW));
        if (bufPop) begin
            nxt_state.bufMem[0] = state_ff.bufMem[1];
        end
        pushSlot = bufPop ? 2'(state_ff.bufCount - 2'h1) : state_ff.bufCount;
        if (bufPush) begin
            // a push only lands below two entries, so the slot fits in one bit
            nxt_state.bufMem[pushSlot[0]] = resultByte;
        end
        nxt_state.bufCount = 2'(state_ff.bufCount + {1'b0, bufPush} - {1'b0, bufPop});

        // data-ready: low once a whole sample sits in the buffer
        if (lastByte && !state_ff.readyLow) begin
            releaseReady = 1'b0;
        end else if (lastByte) begin
            if (state_ff.crcCtl[READY_AFTER_CHECKSUM_BIT]) begin
                nxt_state.waitChecksum = 1'b1;
            end else begin
                releaseReady = 1'b1;
            end
        end
        if (state_ff.waitChecksum && commit && state_ff.addr == ADDR_CHECKSUM_VALUE) begin
            nxt_state.waitChecksum = 1'b0;
            releaseReady = 1'b1;
        end
        if (releaseReady) begin
            nxt_state.readyLow = 1'b0;
        end
        // a new full sample wins over a release in the same cycle
        if (nxt_state.bufCount == 2'(BUF_DEPTH) && bufPush) begin
            nxt_state.readyLow = 1'b1;
        end

        // checksum clear: any write to the value, or ready release unless disabled
        if ((doWrite && state_ff.addr == ADDR_CHECKSUM_VALUE) ||
            (releaseReady && !state_ff.readyCtl[READY_NO_CLEAR_BIT])) begin
            nxt_state.crc = CRC_INIT;
        end

        if (srst) begin
            nxt_state = '0;
            nxt_state.streamCtl = RST_STREAM_CONTROL;
            nxt_state.burstStart = RST_BURST_READ_START;
            nxt_state.burstLen = RST_BURST_READ_LENGTH;
            nxt_state.readyCtl = RST_READY_PIN_CONTROL;
            nxt_state.crcCtl = RST_CHECKSUM_CONTROL;
            nxt_state.pinDir = RST_PIN_DIRECTION;
            nxt_state.crc = CRC_INIT;
            nxt_state.inCmd = 1'b1;
            nxt_state.sclkPrev = 1'b0;
        end
    end

    // single state register
    always_ff @(posedge clock) begin
        state_ff <= nxt_state;
    end

    // general pins: direction per bit, pin six may carry active-low data-ready
    for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
        if (p == READY_PIN) begin : g_ready
            assign pinOe[p] = state_ff.readyCtl[READY_ON_PIN_SIX_BIT] | state_ff.pinDir[p];
            assign pinOut[p] = state_ff.readyCtl[READY_ON_PIN_SIX_BIT] ?
                               !state_ff.readyLow : pinDrive[p];
        end else begin : g_plain
            assign pinOe[p] = state_ff.pinDir[p];
            assign pinOut[p] = pinDrive[p];
        end
        assign pinSeen[p] = pinIn[p];
    end

    // serial output and decoded control fields
    assign sdo = state_ff.txShift[7];
    assign sdoOe = !csLow;
    assign readyLow = !state_ff.readyLow;
    assign streamControlled = state_ff.streamCtl[STREAM_TYPE_BIT];
    assign streamRange = state_ff.streamCtl[6:0];
    assign burstStartAddr = state_ff.burstStart[6:0];
    assign burstByteCount = {1'b0, state_ff.burstLen[2:0]} + 4'h1;
    assign gainBgCorrection = state_ff.readyCtl[GAIN_BG_CORR_BIT];
    assign checksumEnable = state_ff.crcCtl[CHECKSUM_ENABLE_BIT];

endmodule : sensor_afe_spi_control_regs
`default_nettype wire

// ===== test/spi_host_model.sv
// serial host model: sends frames, keeps read bytes in rdBuf
// assumes the device samples its serial inputs on clock; phases held 3 clocks
`default_nettype none
module spi_host_model (
    input wire logic clock,
    output logic sclk,
    output logic csLow,
    output logic mosi,
    input wire logic sdo
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] rdBuf [8];
    // idle: clock low and deselected
    initial begin
        sclk = 1'b0;
        csLow = 1'b1;
        mosi = 1'b0;
    end
    // one byte msb first; sdo is taken just before the rising phase
    task automatic shiftByte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sclk = 1'b0;
            mosi = tx[i];
            repeat (3) @(negedge clock);
            rx[i] = sdo;
            sclk = 1'b1;
            repeat (3) @(negedge clock);
        end
    endtask : shiftByte
    // command byte, then n data bytes each carrying wd
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, input int n);
        logic [7:0] rx;
        csLow = 1'b0;
        shiftByte(cmd, rx);
        for (int k = 0; k < n; k++) begin
            shiftByte(wd, rx);
            rdBuf[k] = rx;
        end
        sclk = 1'b0;
        repeat (3) @(negedge clock);
        csLow = 1'b1;
        mosi = ~mosi; // released line shows no stale bit
        repeat (3) @(negedge clock);
    endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// ===== test/sensor_afe_spi_control_regs_sva.sv
// port checker of the serial control register block
// assumes one clock domain and a synchronous active-high reset
`default_nettype none
module sensor_afe_spi_control_regs_sva (
    input wire logic clock,
    input wire logic srst,
    input wire logic csLow,
    input wire logic resultValid,
    input wire logic resultReady,
    input wire logic [6:0] pinIn,
    input wire logic [6:0] pinDrive,
    input wire logic [6:0] pinOut,
    input wire logic [6:0] pinOe,
    input wire logic [6:0] pinSeen,
    input wire logic readyLow,
    input wire logic streamControlled,
    input wire logic [6:0] streamRange,
    input wire logic [6:0] burstStartAddr,
    input wire logic [3:0] burstByteCount,
    input wire logic gainBgCorrection,
    input wire logic checksumEnable
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    // two deselected edges with no reset before them
    sequence idlePair;
        csLow && !srst ##1 csLow;
    endsequence
    // a result byte taken one or two edges ago
    sequence pushSeen;
        $past(resultValid && resultReady) || $past(resultValid && resultReady, 2);
    endsequence
    fields_hold_a: assert property (idlePair |-> $stable({streamControlled, streamRange,
        burstStartAddr, burstByteCount, gainBgCorrection, checksumEnable, pinOe}))
        else $error("register field changed outside a frame");
    reset_fields_a: assert property ($fell(srst) |-> !streamControlled && streamRange == 7'h00
        && burstStartAddr == 7'h1a && burstByteCount == 4'h3 && !checksumEnable)
        else $error("field not at reset value");
    seen_follows_a: assert property (pinSeen == pinIn)
        else $error("pin level not passed through");
    drive_follows_a: assert property ($stable(pinDrive) && $stable(pinOe) |->
        (pinOut[5:0] & pinOe[5:0]) == (pinDrive[5:0] & pinOe[5:0]))
        else $error("output pin not driving its value");
    six_routing_a: assert property (pinOe[6] && pinOut[6] != pinDrive[6] |-> pinOut[6] == readyLow)
        else $error("pin six shows neither drive nor ready");
    ready_release_a: assert property ($rose(readyLow) && !$past(srst) |-> !csLow || !$past(csLow))
        else $error("ready released outside a read frame");
    ready_assert_a: assert property ($fell(readyLow) |-> pushSeen)
        else $error("ready asserted without a new result");
    full_ready_a: assert property (!resultReady [*2] |-> !readyLow)
        else $error("full buffer without ready asserted");
endmodule : sensor_afe_spi_control_regs_sva
bind sensor_afe_spi_control_regs sensor_afe_spi_control_regs_sva sensor_afe_spi_control_regs_sva_i (
    .clock, .srst, .csLow, .resultValid, .resultReady, .pinIn, .pinDrive, .pinOut, .pinOe,
    .pinSeen, .readyLow, .streamControlled, .streamRange, .burstStartAddr, .burstByteCount,
    .gainBgCorrection, .checksumEnable);
`default_nettype wire

// ===== test/sensor_afe_spi_control_regs_test.sv
// self-checking bench of the serial control register block
// assumes the host model and checker are compiled before it
`default_nettype none
module sensor_afe_spi_control_regs_test;
    import afe_spi_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, srst, sclk, csLow, mosi, sdo, sdoOe, resultValid, resultReady, readyLow;
    logic streamControlled, gainBgCorrection, checksumEnable;
    logic [7:0] resultByte;
    logic [6:0] pinIn, pinDrive, pinOut, pinOe, pinSeen, streamRange, burstStartAddr;
    logic [3:0] burstByteCount;
    int errors = 0;
    int samplesChecked = 0;
    logic [6:0] regAddr [6] = '{ADDR_STREAM_CONTROL, ADDR_BURST_READ_START,
        ADDR_BURST_READ_LENGTH, ADDR_READY_PIN_CONTROL, ADDR_CHECKSUM_CONTROL, ADDR_PIN_DIRECTION};
    logic [7:0] rstVal [6] = '{8'h00, 8'h1a, 8'h02, 8'h03, 8'h08, 8'h00};
    logic [7:0] oneVal [6] = '{8'hff, 8'h7f, 8'h07, 8'hab, 8'h1c, 8'h7f};
    sensor_afe_spi_control_regs sensor_afe_spi_control_regs_i (.clock, .srst, .sclk, .csLow,
        .mosi, .sdo, .sdoOe, .resultByte, .resultValid, .resultReady, .pinIn, .pinDrive,
        .pinOut, .pinOe, .pinSeen, .readyLow, .streamControlled, .streamRange, .burstStartAddr,
        .burstByteCount, .gainBgCorrection, .checksumEnable);
    spi_host_model spi_host_model_i (.clock, .sclk, .csLow, .mosi, .sdo);
    // 25 MHz clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task automatic summarize();
        $display("checked %0d mismatches %0d", samplesChecked, errors);
        if (errors == 0 && samplesChecked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        spi_host_model_i.xfer({1'b0, a}, d, 1);
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        spi_host_model_i.xfer({1'b1, a}, 8'h00, 1);
        check($sformatf("reg %h", a), spi_host_model_i.rdBuf[0], exp);
    endtask : rd
    // offer one result byte and hold it until taken
    task automatic push(input logic [7:0] b);
        int i;
        resultByte = b;
        resultValid = 1'b1;
        for (i = 0; i < 50 && resultReady !== 1'b1; i++) @(negedge clock);
        if (i == 50) begin
            errors++;
            summarize();
        end
        @(negedge clock);
        resultValid = 1'b0;
    endtask : push
    // checksum step, polynomial x^8 + x^2 + x + 1, msb first
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int i = 0; i < 8; i++) r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
        return r;
    endfunction : crc8
    // main sequence: registers, pins, streaming, result and checksum
    initial begin
        {srst, resultValid, resultByte, pinIn, pinDrive} = {1'b1, 9'h0, 7'h2a, 7'h15};
        repeat (6) @(negedge clock);
        srst = 1'b0;
        foreach (regAddr[i]) rd(regAddr[i], rstVal[i]);
        check("ports", {2'h0, sdoOe, checksumEnable, burstByteCount}, 8'h03);
        foreach (regAddr[i]) begin
            wr(regAddr[i], i == 3 ? 8'hab : 8'hff);
            rd(regAddr[i], oneVal[i]);
        end
        wr(7'h20, 8'hff);
        rd(7'h20, 8'h00);
        check("stream", {streamControlled, streamRange}, 8'hff);
        check("start", {1'b0, burstStartAddr}, 8'h7f);
        check("flags", {2'h0, gainBgCorrection, checksumEnable, burstByteCount}, 8'h38);
        check("routed", {pinOut[6], pinOe}, 8'hff);
        check("drive", {2'h0, pinOut[5:0]}, 8'h15);
        wr(ADDR_BURST_READ_LENGTH, 8'h00);
        wr(ADDR_READY_PIN_CONTROL, 8'h03);
        wr(ADDR_PIN_DIRECTION, 8'h40);
        check("count", {4'h0, burstByteCount}, 8'h01);
        check("gpio six", {pinOut[6], pinOe}, 8'h40);
        $display("register test done");
        for (int m = 0; m < 2; m++) begin
            wr(ADDR_STREAM_CONTROL, m ? 8'h81 : 8'h00);
            spi_host_model_i.xfer({1'b1, ADDR_BURST_READ_START}, 8'h00, 3 + m);
            for (int k = 0; k < 3 + m; k++) begin
                check("burst", spi_host_model_i.rdBuf[k], (k % 2 == 0 && (m == 1 || k == 0)) ? 8'h7f : 8'h00);
            end
        end
        $display("streaming test done");
        for (int m = 0; m < 2; m++) begin
            wr(ADDR_READY_PIN_CONTROL, m ? 8'ha3 : 8'h83);
            wr(ADDR_CHECKSUM_CONTROL, m ? 8'h1c : 8'h18);
            push(8'h3c + 8'(m));
            push(8'hc5 - 8'(m));
            @(negedge clock);
            check("full", {5'h0, resultReady, readyLow, pinOut[6]}, 8'h00);
            rd(ADDR_RESULT_HIGH, 8'h3c + 8'(m));
            wr(ADDR_CHECKSUM_VALUE, 8'h5a);
            rd(ADDR_RESULT_LOW, 8'hc5 - 8'(m));
            check("after low", {7'h0, readyLow}, m ? 8'h00 : 8'h01);
            rd(ADDR_CHECKSUM_VALUE, m ? crc8(8'h00, 8'hc4) : 8'h00);
            check("after crc", {7'h0, readyLow}, 8'h01);
        end
        $display("result test done");
        summarize();
    end
endmodule : sensor_afe_spi_control_regs_test
`default_nettype wire
